//--- hw/epc_cfg.svh
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH
// How it works
// [R01] Scratch write: address, data to end, CRC, ones
// [R02] Scratch read: address, status, data, CRC, ones
// [R03] Bad copy: no programming, all-ones loop
// [R04] Master authorizes copy with address and status
// [R05] Master keeps bus idle while programming
// [R06] Good copy finishes into alternating pattern loop
// [R07] Memory read streams to end, else ones
// [R08] Read from zero yields 550 bytes
// [R09] Register write needs valid address, else ones
// [R10] Pin read and write loop until reset
// [R11] Pin write: byte, complement, confirm, pin state
// [R12] Bad complement on pin write: ones loop
// [R13] Pin pulse: mask, complement, confirm, pin state
// [R14] Bad pulse mask complement: ones loop
// [R15] Activity clear then alternating pattern loop
// [R16] Code 0Fh is scratch write
// [R17] Code AAh is scratch read
// [R18] Status byte: ending offset, accept, partial flags
// [R19] Low address byte first, LSB first
// [R20] Master checks trailing CRC after reading
// [R21] Codes F5h, 5Ah, A5h are pin commands
// [R22] INVERTED_A cleared per command, sent inverted
// [R23] Write CRC only when offset reaches 31
// [R24] Register write covers 223h to 225h
// [R25] Bus reset aborts any command
// [R26] Rejected pin command changes nothing

// Command codes
`define EPC_CMD_WRITE   8'h0f
`define EPC_CMD_READ    8'haa
`define EPC_CMD_COPY    8'h55
`define EPC_CMD_MEMRD   8'hf0
`define EPC_CMD_REGWR   8'hcc
`define EPC_CMD_PINRD   8'hf5
`define EPC_CMD_PINWR   8'h5a
`define EPC_CMD_PULSE   8'ha5
`define EPC_CMD_ACTCLR  8'hc3
// Answer bytes
`define EPC_ONES        8'hff
`define EPC_ALT         8'haa
// Address map
`define EPC_MEM_TOP     10'h1ff
`define EPC_REG_BASE    10'h200
`define EPC_REG_PIN     10'h220
`define EPC_REG_LATCH   10'h221
`define EPC_REG_ACT     10'h222
`define EPC_REG_WR_LO   10'h223
`define EPC_ADDR_LAST   10'h225
// Status byte fields
`define EPC_ES_AUTH     7
`define EPC_ES_PF       5
// CRC
`define EPC_CRC_POLY    16'ha001
// Timing
`define EPC_PROG_NS     10000000
`define EPC_CLK_NS      20
`define EPC_PROG_CYC    (`EPC_PROG_NS / `EPC_CLK_NS)
`define EPC_PULSE_CYC   16
`define EPC_PIN_SAMPLES 32
`endif

//--- hw/epc_pkg.sv
package epc_pkg;
  typedef enum {
    ST_IDLE, ST_CMD, ST_ADDR_LO, ST_ADDR_HI, ST_WS_DATA, ST_CRC_LO, ST_CRC_HI,
    ST_RS_HDR, ST_RS_DATA, ST_CP_ES, ST_PROG, ST_MR_DATA, ST_WR_DATA,
    ST_PR_DATA, ST_PW_FIRST, ST_PW_SECOND, ST_PW_CONF, ST_PW_PIN,
    ST_FF_LOOP, ST_AA_LOOP
  } epc_state_e;
  typedef logic [7:0] epc_byte_t;
endpackage : epc_pkg

//--- hw/epc_top.sv
`include "epc_cfg.svh"

// --------------------
// Answer FIFO
// --------------------
module epc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full and empty straight from the occupancy count
  assign in_ready_out  = (count != (AW+1)'(DEPTH)) && !flush_in;
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  // Pointers and count; flush drops anything queued for an aborted command
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk_in) begin
    if (push) mem[wr_ptr] <= in_data_in;
  end
endmodule : epc_fifo

// --------------------
// Function-command interpreter
// --------------------
module epc_top #(
  parameter int PROG_CYCLES  = `EPC_PROG_CYC,
  parameter int PULSE_CYCLES = `EPC_PULSE_CYC,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       bus_reset_in,
  input  wire logic       rom_selected_in,
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  output logic      [7:0] tx_data_out,
  input  wire logic [15:0] page_protect_in,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_latch_out,
  output logic      [1:0] pin_pulse_out,
  output logic      [1:0] activity_out,
  output logic            programming_out
);
  logic                rst_meta;
  logic                rst_n;
  epc_pkg::epc_state_e state;
  epc_pkg::epc_byte_t  cmd;
  epc_pkg::epc_byte_t  target_addr_low;
  epc_pkg::epc_byte_t  target_addr_high;
  epc_pkg::epc_byte_t  first_byte;
  logic [4:0]          ending_offset;
  logic                partial_byte_flag;
  logic                authorization_accepted_flag;
  logic [15:0]         crc;
  logic [9:0]          addr;
  logic [5:0]          idx;
  logic [1:0]          hdr_cnt;
  logic                crc_to_pin;
  logic [31:0]         prog_cnt;
  logic [15:0]         pulse_cnt;
  logic [1:0]          pin_prev;
  logic                push_valid;
  epc_pkg::epc_byte_t  push_data;
  logic                push_ready;
  logic                push;
  logic                take;
  logic                act_clear;
  epc_pkg::epc_byte_t  scratch [32];
  epc_pkg::epc_byte_t  memory [512];
  epc_pkg::epc_byte_t  user_reg [3];
  epc_pkg::epc_byte_t  es_byte;
  epc_pkg::epc_byte_t  pin_byte;

  // INVERTED_A over one byte, LSB first, reflected x^16+x^15+x^2+1
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `EPC_CRC_POLY) : (r >> 1); // [R22]
    end
    return r;
  endfunction : crc_upd

  // Byte image of the addressable space; used by memory read only
  function automatic epc_pkg::epc_byte_t space_rd(input logic [9:0] a);
    epc_pkg::epc_byte_t v;
    v = `EPC_ONES;
    if (a <= `EPC_MEM_TOP) v = memory[a[8:0]];
    else if (a == `EPC_REG_PIN) v = pin_byte;
    else if (a == `EPC_REG_LATCH) v = {6'h3f, pin_latch_out};
    else if (a == `EPC_REG_ACT) v = {6'h00, activity_out};
    else if (a >= `EPC_REG_WR_LO && a <= `EPC_ADDR_LAST) v = user_reg[2'(a - `EPC_REG_WR_LO)];
    else v = 8'h00;
    return v;
  endfunction : space_rd

  // --------------------
  // Reset release
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign es_byte = {authorization_accepted_flag, 1'b0, partial_byte_flag, ending_offset}; // [R18]
  assign pin_byte = {6'h3f, pin_in};
  assign addr = {target_addr_high[1:0], target_addr_low};   // [R19]
  assign take = rx_valid_in;
  assign push = push_valid && push_ready;
  assign act_clear = take && state == epc_pkg::ST_CMD && rx_data_in == `EPC_CMD_ACTCLR;
  assign programming_out = (state == epc_pkg::ST_PROG);

  // --------------------
  // Answer byte selection
  // --------------------
  // Idle loops keep pushing; the FIFO fills and stalls them until read
  always_comb begin
    push_valid = 1'b1;
    push_data  = `EPC_ONES;
    case (state)
      epc_pkg::ST_CRC_LO:  push_data = ~crc[7:0];                      // [R22]
      epc_pkg::ST_CRC_HI:  push_data = ~crc[15:8];
      epc_pkg::ST_RS_HDR:  push_data = (hdr_cnt == 2'd0) ? target_addr_low :
                                       (hdr_cnt == 2'd1) ? target_addr_high : es_byte; // [R02]
      epc_pkg::ST_RS_DATA: push_data = scratch[idx[4:0]];
      epc_pkg::ST_MR_DATA: push_data = space_rd(addr);                 // [R07]
      epc_pkg::ST_PR_DATA: push_data = pin_byte;                       // [R10]
      epc_pkg::ST_PW_CONF: push_data = `EPC_ALT;                       // [R11] [R13]
      epc_pkg::ST_PW_PIN:  push_data = pin_byte;
      epc_pkg::ST_FF_LOOP: push_data = `EPC_ONES;
      epc_pkg::ST_AA_LOOP: push_data = `EPC_ALT;                       // [R06] [R15]
      default:             push_valid = 1'b0;
    endcase
  end

  epc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (ref_clk_in),
    .rst_n_in      (rst_n),
    .flush_in      (bus_reset_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in),
    .out_data_out  (tx_data_out)
  );

  // --------------------
  // Command sequencer
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state            <= epc_pkg::ST_IDLE;
      cmd              <= 8'h00;
      target_addr_low  <= 8'h00;
      target_addr_high <= 8'h00;
      first_byte       <= 8'h00;
      idx              <= 6'h00;
      hdr_cnt          <= 2'd0;
      crc_to_pin       <= 1'b0;
      prog_cnt         <= '0;
    end else if (bus_reset_in) begin
      state <= epc_pkg::ST_IDLE;                                       // [R25]
    end else begin
      case (state)
        epc_pkg::ST_IDLE: if (rom_selected_in) state <= epc_pkg::ST_CMD;
        epc_pkg::ST_CMD: if (take) begin
          cmd <= rx_data_in;
          idx <= 6'h00;
          hdr_cnt <= 2'd0;
          crc_to_pin <= 1'b0;
          case (rx_data_in)
            `EPC_CMD_WRITE, `EPC_CMD_COPY, `EPC_CMD_MEMRD,
            `EPC_CMD_REGWR:  state <= epc_pkg::ST_ADDR_LO;             // [R16] [R04]
            `EPC_CMD_READ:   state <= epc_pkg::ST_RS_HDR;              // [R17]
            `EPC_CMD_PINRD:  state <= epc_pkg::ST_PR_DATA;             // [R21]
            `EPC_CMD_PINWR,
            `EPC_CMD_PULSE:  state <= epc_pkg::ST_PW_FIRST;            // [R21]
            `EPC_CMD_ACTCLR: state <= epc_pkg::ST_AA_LOOP;             // [R15]
            default:         state <= epc_pkg::ST_IDLE;
          endcase
        end
        epc_pkg::ST_ADDR_LO: if (take) begin
          first_byte <= rx_data_in;                                    // [R19]
          state <= epc_pkg::ST_ADDR_HI;
        end
        epc_pkg::ST_ADDR_HI: if (take) begin
          if (cmd == `EPC_CMD_COPY) begin
            // Copy compares against the stored address, so hold the low byte aside in first_byte and compare the high byte as it arrives
            state <= (first_byte == target_addr_low && rx_data_in == target_addr_high)
                     ? epc_pkg::ST_CP_ES : epc_pkg::ST_FF_LOOP;         // [R03]
          end else begin
            target_addr_low  <= first_byte;
            target_addr_high <= rx_data_in;
            idx <= {1'b0, first_byte[4:0]};
            if (cmd == `EPC_CMD_WRITE) state <= epc_pkg::ST_WS_DATA;
            else if (cmd == `EPC_CMD_MEMRD)
              state <= ({rx_data_in, first_byte} <= 16'(`EPC_ADDR_LAST))
                       ? epc_pkg::ST_MR_DATA : epc_pkg::ST_FF_LOOP;     // [R07]
            else
              state <= ({rx_data_in, first_byte} >= 16'(`EPC_REG_WR_LO) &&
                        {rx_data_in, first_byte} <= 16'(`EPC_ADDR_LAST))
                       ? epc_pkg::ST_WR_DATA : epc_pkg::ST_FF_LOOP;     // [R09] [R24]
          end
        end
        epc_pkg::ST_WS_DATA: if (take) begin
          if (idx[4:0] == 5'h1f) state <= epc_pkg::ST_CRC_LO;         // [R23] [R01]
          else idx <= idx + 6'h01;
        end
        epc_pkg::ST_CRC_LO: if (push) state <= epc_pkg::ST_CRC_HI;
        epc_pkg::ST_CRC_HI: if (push) begin
          idx   <= 6'h00;
          state <= crc_to_pin ? epc_pkg::ST_PR_DATA : epc_pkg::ST_FF_LOOP; // [R10]
        end
        epc_pkg::ST_RS_HDR: if (push) begin
          hdr_cnt <= hdr_cnt + 2'd1;
          idx <= {1'b0, target_addr_low[4:0]};
          if (hdr_cnt == 2'd2) state <= epc_pkg::ST_RS_DATA;
        end
        epc_pkg::ST_RS_DATA: if (push) begin
          if (idx[4:0] >= ending_offset) state <= epc_pkg::ST_CRC_LO;  // [R02]
          else idx <= idx + 6'h01;
        end
        epc_pkg::ST_CP_ES: if (take) begin
          idx <= {1'b0, target_addr_low[4:0]};
          prog_cnt <= '0;
          state <= (rx_data_in == es_byte && !partial_byte_flag &&
                    addr <= `EPC_MEM_TOP && !page_protect_in[addr[8:5]])
                   ? epc_pkg::ST_PROG : epc_pkg::ST_FF_LOOP;           // [R03]
        end
        epc_pkg::ST_PROG: begin
          // Busy for the whole programming time; master keeps the bus idle
          prog_cnt <= prog_cnt + 32'd1;                                // [R05]
          if (idx[4:0] < ending_offset) idx <= idx + 6'h01;
          if (prog_cnt == 32'(PROG_CYCLES - 1)) state <= epc_pkg::ST_AA_LOOP; // [R06]
        end
        epc_pkg::ST_MR_DATA: if (push) begin
          if (addr == `EPC_ADDR_LAST) state <= epc_pkg::ST_FF_LOOP;   // [R08]
          else {target_addr_high, target_addr_low} <= {target_addr_high, target_addr_low} + 16'h0001;
        end
        epc_pkg::ST_WR_DATA: if (take) begin
          if (addr == `EPC_ADDR_LAST) state <= epc_pkg::ST_FF_LOOP;   // [R24]
          else target_addr_low <= target_addr_low + 8'h01;
        end
        epc_pkg::ST_PR_DATA: if (push) begin
          if (idx == 6'(`EPC_PIN_SAMPLES - 1)) begin
            crc_to_pin <= 1'b1;
            state <= epc_pkg::ST_CRC_LO;
          end else idx <= idx + 6'h01;
        end
        epc_pkg::ST_PW_FIRST: if (take) begin
          first_byte <= rx_data_in;
          state <= epc_pkg::ST_PW_SECOND;
        end
        epc_pkg::ST_PW_SECOND: if (take) begin
          state <= (rx_data_in == ~first_byte)
                   ? epc_pkg::ST_PW_CONF : epc_pkg::ST_FF_LOOP;        // [R12] [R14]
        end
        epc_pkg::ST_PW_CONF: if (push) state <= epc_pkg::ST_PW_PIN;
        epc_pkg::ST_PW_PIN: if (push) begin
          state <= (cmd == `EPC_CMD_PINWR) ? epc_pkg::ST_PW_FIRST : epc_pkg::ST_FF_LOOP; // [R10]
        end
        epc_pkg::ST_FF_LOOP: state <= epc_pkg::ST_FF_LOOP;
        epc_pkg::ST_AA_LOOP: state <= epc_pkg::ST_AA_LOOP;
        default: state <= epc_pkg::ST_IDLE;
      endcase
    end
  end

  // --------------------
  // CRC accumulator
  // --------------------
  // Received bytes fold in for writes, sent bytes for reads
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      crc <= 16'h0000;
    end else if (take && state == epc_pkg::ST_CMD) begin
      crc <= crc_upd(16'h0000, rx_data_in);                            // [R22]
    end else if (take && (state == epc_pkg::ST_ADDR_LO || state == epc_pkg::ST_ADDR_HI ||
                          state == epc_pkg::ST_WS_DATA)) begin
      crc <= crc_upd(crc, rx_data_in);
    end else if (push && (state == epc_pkg::ST_RS_HDR || state == epc_pkg::ST_RS_DATA)) begin
      crc <= crc_upd(crc, push_data);
    end else if (push && state == epc_pkg::ST_PR_DATA) begin
      // Later passes start from a cleared generator
      crc <= crc_upd((idx == 6'h00 && crc_to_pin) ? 16'h0000 : crc, push_data);
    end
  end

  // --------------------
  // Scratchpad status
  // --------------------
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ending_offset               <= 5'h1f;
      partial_byte_flag           <= 1'b1;
      authorization_accepted_flag <= 1'b0;
    end else if (state == epc_pkg::ST_ADDR_HI && take && cmd == `EPC_CMD_WRITE) begin
      // Flag stays set until a complete data byte lands
      partial_byte_flag           <= 1'b1;
      authorization_accepted_flag <= 1'b0;
      ending_offset               <= first_byte[4:0];
    end else if (state == epc_pkg::ST_WS_DATA && take) begin
      partial_byte_flag <= 1'b0;
      ending_offset     <= idx[4:0];                                   // [R18]
    end else if (state == epc_pkg::ST_CP_ES && take && rx_data_in == es_byte &&
                 !partial_byte_flag && addr <= `EPC_MEM_TOP &&
                 !page_protect_in[addr[8:5]]) begin                   // [R03]
      authorization_accepted_flag <= 1'b1;
    end
  end

  // Data stores: no reset, contents survive
  always_ff @(posedge ref_clk_in) begin
    if (state == epc_pkg::ST_WS_DATA && take) scratch[idx[4:0]] <= rx_data_in; // [R01]
    if (state == epc_pkg::ST_PROG && prog_cnt <= 32'(ending_offset))
      memory[{addr[8:5], idx[4:0]}] <= scratch[idx[4:0]];
    if (state == epc_pkg::ST_WR_DATA && take)
      user_reg[2'(addr - `EPC_REG_WR_LO)] <= rx_data_in;               // [R09]
  end

  // --------------------
  // Pin latch, pulse and activity
  // --------------------
  // Only an accepted complement pair touches the latch or the pulse timer
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_latch_out <= 2'b11;
      pin_pulse_out <= 2'b00;
      pulse_cnt     <= 16'h0000;
    end else begin
      if (state == epc_pkg::ST_PW_SECOND && take && rx_data_in == ~first_byte) begin // [R26]
        if (cmd == `EPC_CMD_PINWR) pin_latch_out <= first_byte[1:0];  // [R11]
        else begin
          pin_pulse_out <= ~first_byte[1:0];                           // [R13]
          pulse_cnt     <= 16'(PULSE_CYCLES);
        end
      end else if (pulse_cnt != 16'h0000) begin
        pulse_cnt <= pulse_cnt - 16'h0001;
        if (pulse_cnt == 16'h0001) pin_pulse_out <= 2'b00;
      end
    end
  end

  // Activity latches; a pin edge in the clear cycle still sets
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev     <= 2'b11;
      activity_out <= 2'b00;
    end else begin
      pin_prev     <= pin_in;
      activity_out <= (act_clear ? 2'b00 : activity_out) | (pin_in ^ pin_prev); // [R15]
    end
  end
endmodule : epc_top

//--- testbench/epc_top_props.sv
// --------------------
// Port-level checker for the interpreter
// --------------------
module epc_top_props #(
  parameter int PULSE_CYCLES = 16
) (
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic       bus_reset_in,
  input wire logic       rx_valid_in,
  input wire logic       tx_valid_out,
  input wire logic       tx_ready_in,
  input wire logic [7:0] tx_data_out,
  input wire logic [1:0] pin_latch_out,
  input wire logic [1:0] pin_pulse_out,
  input wire logic       programming_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic [7:0] pcnt;
  // Pulse length counter; an exact figure catches a pulse cut short
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pcnt <= 8'h00;
    end else begin
      pcnt <= (|pin_pulse_out) ? pcnt + 8'h01 : 8'h00;
    end
  end
  a_bus_flush: assert property (bus_reset_in |=> !tx_valid_out)
    else $error("answer kept after link reset");
  a_head_hold: assert property (tx_valid_out && !tx_ready_in && !bus_reset_in |=>
    tx_valid_out && $stable(tx_data_out)) else $error("answer byte lost");
  a_prog_span: assert property ($rose(programming_out) |-> programming_out [*8])
    else $error("programming too short");
  a_prog_quiet: assert property (programming_out |-> !tx_valid_out)
    else $error("answer while programming");
  a_prog_cause: assert property ($rose(programming_out) |->
    $past(rx_valid_in) || $past(rx_valid_in, 2)) else $error("programming unasked");
  a_latch_cause: assert property ($changed(pin_latch_out) |->
    $past(rx_valid_in) || $past(rx_valid_in, 2) || $past(rx_valid_in, 3))
    else $error("latch moved unasked");
  a_pulse_cause: assert property ($rose(|pin_pulse_out) |->
    $past(rx_valid_in) || $past(rx_valid_in, 2) || $past(rx_valid_in, 3))
    else $error("pulse unasked");
  a_pulse_long: assert property (|pin_pulse_out |-> pcnt < PULSE_CYCLES)
    else $error("pulse too long");
  a_pulse_full: assert property ($fell(|pin_pulse_out) |-> pcnt == PULSE_CYCLES)
    else $error("pulse too short");
  c_prog: cover property ($rose(programming_out));
  c_pulse: cover property ($rose(|pin_pulse_out));
  c_latch: cover property ($changed(pin_latch_out));
endmodule : epc_top_props

bind epc_top epc_top_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_epc_top_props (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .bus_reset_in(bus_reset_in),
  .rx_valid_in(rx_valid_in), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .tx_data_out(tx_data_out), .pin_latch_out(pin_latch_out),
  .pin_pulse_out(pin_pulse_out), .programming_out(programming_out));

//--- testbench/epc_mst.sv
// --------------------
// Byte-level bus master model
// --------------------
module epc_mst (
  input  wire logic       clk_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  output logic            tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int   stall = 0;
  logic hung  = 1'b0;
  // Idle master: no byte, no read slot
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    tx_ready_out = 1'b0;
  end
  // One byte per call; released data shows the inverse
  task put(input logic [7:0] v);
    rx_valid_out <= 1'b1;
    rx_data_out  <= v;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~v;
    @(posedge clk_in);
  endtask : put
  // Read slot; data sampled on the falling edge before the rising edge where valid and ready meet
  task take(output logic [7:0] v);
    int n;
    n = 0;
    repeat (stall) @(posedge clk_in);
    tx_ready_out <= 1'b1;
    do begin
      @(negedge clk_in);
      n++;
    end while (tx_valid_in !== 1'b1 && n < 2000);
    if (n >= 2000) hung = 1'b1;
    v = tx_data_in;
    @(posedge clk_in);
    tx_ready_out <= 1'b0;
    @(posedge clk_in);
  endtask : take
endmodule : epc_mst

//--- testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in, rstn_in, bus_reset_in, rom_selected_in, rx_valid_in;
  logic        tx_valid_out, tx_ready_in, programming_out, seen_prog;
  logic [7:0]  rx_data_in, tx_data_out, b;
  logic [15:0] page_protect_in, crc;
  logic [1:0]  pin_in, pin_latch_out, pin_pulse_out, activity_out, seen_pulse;
  int          n_fail, comparisons, i, p;
  // --------------------
  // Design, master model, clock
  // --------------------
  epc_top #(.PROG_CYCLES(20)) u_epc_top (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .bus_reset_in(bus_reset_in), .rom_selected_in(rom_selected_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .tx_valid_out(tx_valid_out),
    .tx_ready_in(tx_ready_in), .tx_data_out(tx_data_out), .page_protect_in(page_protect_in),
    .pin_in(pin_in), .pin_latch_out(pin_latch_out), .pin_pulse_out(pin_pulse_out),
    .activity_out(activity_out), .programming_out(programming_out));
  epc_mst u_epc_mst (.clk_in(ref_clk_in), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .tx_ready_out(tx_ready_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // Sticky records, since programming ends before bytes are read; the pulse still runs when they are read
  always @(posedge ref_clk_in) begin
    seen_prog  <= seen_prog | programming_out;
    seen_pulse <= seen_pulse | pin_pulse_out;
  end
  function automatic logic [15:0] cu(input logic [15:0] c, input logic [7:0] d);
    for (int k = 0; k < 8; k++) c = (c[0] ^ d[k]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction : cu
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task gt(output logic [7:0] v);
    u_epc_mst.take(v);
    if (u_epc_mst.hung) begin
      n_fail++;
      print_verdict();
    end
  endtask : gt
  task ex(input logic [7:0] e);
    gt(b);
    chk("answer", b, e);
  endtask : ex
  // Link reset, selection, then the command byte
  task open(input logic [7:0] c);
    bus_reset_in <= 1'b1;
    @(posedge ref_clk_in);
    bus_reset_in    <= 1'b0;
    rom_selected_in <= 1'b1;
    @(negedge ref_clk_in);
    chk("flush", {7'h00, tx_valid_out}, 8'h00);
    @(posedge ref_clk_in);
    rom_selected_in <= 1'b0;
    @(posedge ref_clk_in);
    u_epc_mst.put(c);
  endtask : open
  task cmd(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    open(c);
    u_epc_mst.put(lo);
    u_epc_mst.put(hi);
  endtask : cmd
  // --------------------
  // Command sequences
  // --------------------
  initial begin
    {rstn_in, bus_reset_in, rom_selected_in, seen_prog} = 4'h0;
    {page_protect_in, pin_in, seen_pulse} = 20'h0000c;
    {n_fail, comparisons} = 0;
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    pin_in <= 2'b10;
    repeat (4) @(posedge ref_clk_in);
    // Write to the scratchpad end: CRC then ones
    cmd(8'h0f, 8'h1e, 8'h00);
    crc = cu(cu(cu(16'h0000, 8'h0f), 8'h1e), 8'h00);
    for (i = 0; i < 2; i++) begin
      u_epc_mst.put(8'hd0 + i[7:0]);
      crc = cu(crc, 8'hd0 + i[7:0]);
    end
    ex(~crc[7:0]);
    ex(~crc[15:8]);
    ex(8'hff);
    // Short write, then read back header, data and CRC
    cmd(8'h0f, 8'h21, 8'h00);
    for (i = 0; i < 5; i++) u_epc_mst.put(8'h30 + i[7:0]);
    open(8'haa);
    crc = cu(16'h0000, 8'haa);
    for (i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h21 : (i == 1) ? 8'h00 : (i == 2) ? 8'h05 : 8'h2d + i[7:0];
      ex(b);
      crc = cu(crc, b);
    end
    ex(~crc[7:0]);
    ex(~crc[15:8]);
    ex(8'hff);
    // Copy to a protected page is refused, then a good copy
    page_protect_in <= 16'h0002;
    cmd(8'h55, 8'h21, 8'h00);
    u_epc_mst.put(8'h05);
    ex(8'hff);
    chk("prog", {7'h00, seen_prog}, 8'h00);
    page_protect_in <= 16'h0000;
    cmd(8'h55, 8'h21, 8'h00);
    u_epc_mst.put(8'h05);
    for (i = 0; i < 200 && !(seen_prog && !programming_out); i++) @(posedge ref_clk_in);
    ex(8'haa);
    chk("prog", {7'h00, seen_prog}, 8'h01);
    // Register write, good and bad start address
    cmd(8'hcc, 8'h23, 8'h02);
    for (i = 0; i < 3; i++) u_epc_mst.put(8'h60 + i[7:0]);
    ex(8'hff);
    cmd(8'hcc, 8'h22, 8'h02);
    ex(8'hff);
    // Whole memory with a stalling reader, so the answer FIFO fills
    u_epc_mst.stall = 40;
    cmd(8'hf0, 8'h00, 8'h00);
    for (i = 0; i < 550; i++) begin
      gt(b);
      u_epc_mst.stall = 0;
      if (i >= 'h21 && i < 'h26) chk("mem", b, 8'h0f + i[7:0]);
      if (i >= 'h223) chk("reg", b, 8'h3d + i[7:0]);
    end
    ex(8'hff);
    cmd(8'hf0, 8'h26, 8'h02);
    ex(8'hff);
    // Pin write twice in one command, then a bad complement
    cmd(8'h5a, 8'hff, 8'h00);
    ex(8'haa);
    ex(8'hfe);
    u_epc_mst.put(8'hfc);
    u_epc_mst.put(8'h03);
    ex(8'haa);
    ex(8'hfe);
    chk("latch", {6'h00, pin_latch_out}, 8'h00);
    cmd(8'h5a, 8'h12, 8'h12);
    ex(8'hff);
    chk("latch", {6'h00, pin_latch_out}, 8'h00);
    // Pulse: bad mask first, then pin 0
    cmd(8'ha5, 8'hfe, 8'h02);
    ex(8'hff);
    chk("pulse", {6'h00, seen_pulse}, 8'h00);
    cmd(8'ha5, 8'hfe, 8'h01);
    ex(8'haa);
    ex(8'hfe);
    chk("pulse", {6'h00, seen_pulse}, 8'h01);
    // Pin read: two passes, CRC cleared between them
    open(8'hf5);
    crc = cu(16'h0000, 8'hf5);
    for (p = 0; p < 2; p++) begin
      for (i = 0; i < 32; i++) begin
        ex(8'hfe);
        crc = cu(crc, 8'hfe);
      end
      ex(~crc[7:0]);
      ex(~crc[15:8]);
      crc = 16'h0000;
    end
    // Activity clear after the pin 0 change
    chk("act", {6'h00, activity_out}, 8'h01);
    open(8'hc3);
    ex(8'haa);
    ex(8'haa);
    chk("act", {6'h00, activity_out}, 8'h00);
    print_verdict();
  end
endmodule : tb_top
